// *** include/edc_pkg.sv ***
// Constants, types and register map of the external bus DMA channel
package edc_pkg;

  // Register byte addresses on the Wishbone bus
  localparam logic [23:0] REG_SRC = 24'hFFFC80;
  localparam logic [23:0] REG_DST = 24'hFFFC84;
  localparam logic [23:0] REG_STEP = 24'hFFFC88;
  localparam logic [23:0] REG_COUNT = 24'hFFFC8C;
  localparam logic [23:0] REG_MODE = 24'hFFFC94;
  localparam logic [23:0] REG_ADDRCTL = 24'hFFFC98;
  localparam logic [23:0] REG_IRQ_STS = 24'hFFFC9C;
  localparam logic [23:0] REG_IRQ_MSK = 24'hFFFCA0;

  // Mode control fields
  localparam int XFER_EN_BIT = 31;
  localparam int REQ_SENSE_BIT = 27;
  localparam int END_FLAG_BIT = 16;
  localparam int SIZE_LSB = 14;
  localparam int MODE_LSB = 12;
  localparam int END_IE_BIT = 8;
  localparam int SRC_SEL_LSB = 6;
  localparam int PRIO_LSB = 0;
  localparam logic [31:0] MODE_WMASK = 32'h8800_F1C7;

  // Address control fields
  localparam int AMODE_BIT = 31;
  localparam int SUPD_LSB = 20;
  localparam int DUPD_LSB = 16;
  localparam logic [31:0] ADDRCTL_WMASK = 32'h8033_0000;

  // Field codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic AMODE_DUAL = 1'b0;
  localparam logic [1:0] UPD_FIXED = 2'h0;
  localparam logic [1:0] UPD_OFFSET = 2'h1;
  localparam logic [1:0] UPD_INC = 2'h2;
  localparam logic [1:0] UPD_DEC = 2'h3;

  // Interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_END_BIT = 0;
  localparam int IRQ_BEAT_BIT = 1;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11,
    ST_STEP = 2'b10
  } edc_state_e;

  typedef struct packed {
    edc_state_e st;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] step;
    logic [31:0] count;
    logic [31:0] mode;
    logic [31:0] addrctl;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] msk;
    logic first_pend;
    logic req_prev;
    logic edge_pend;
    logic [31:0] hold;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
  } edc_state_s;

endpackage : edc_pkg

// *** src/edc_channel.sv ***
// One external bus DMA channel with Wishbone register slave and memory master port
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
// What this block does
// R1: Transfers run only while the transfer enable bit is one.
// R2: Request sense bit picks low level (0) or falling edge (1) detection.
// R3: With edge sense, first request after enabling is taken on low level.
// R4: Two-bit access size; 00 gives byte accesses.
// R5: Two-bit transfer mode field; 00 gives normal transfer mode.
// R6: Two-bit activation source; 11 means the external request pin.
// R7: Three-bit priority field ranks channel against CPU; 111 is highest.
// R8: Interrupt enable gates the transfer end interrupt request.
// R9: Transfer end flag in mode register shows end request occurred.
// R10: Address mode bit; zero selects dual address read then write.
// R11: Source update field; 01 adds the offset after each transfer.
// R12: Destination update field; 01 adds the offset after each transfer.
// R13: Hardware rewrites source address with next value after each transfer.
// R14: Hardware rewrites destination address with next value after each transfer.
// R15: Byte count drops by the access size bytes on each transfer.
// R16: On-chip peripheral interrupts must not be used to start the channel.
// R17: At count zero: set end flag, clear enable, interrupt if enabled.
// R18: Offset mode adds a programmable offset register to the address.
module edc_channel (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [23:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic ext_transfer_request_n_in,
  output logic bus_req_out,
  input wire logic bus_gnt_in,
  output logic [2:0] cpu_priority_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [1:0] mem_size_out,
  output logic [31:0] mem_wdata_out,
  input wire logic [31:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic irq_out
);
  import edc_pkg::*;

  edc_state_s r;
  edc_state_s nxt;

  function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_sel

  // Reserved size code is treated as a long access
  function automatic logic [31:0] size_bytes(input logic [1:0] code);
    logic [31:0] n;
    unique case (code)
      SIZE_BYTE: n = 32'h0000_0001; // R4
      SIZE_WORD: n = 32'h0000_0002;
      default: n = 32'h0000_0004;
    endcase
    return n;
  endfunction : size_bytes

  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] upd,
                                            input logic [31:0] sz, input logic [31:0] ofs);
    logic [31:0] n;
    unique case (upd)
      UPD_FIXED: n = a;
      UPD_OFFSET: n = a + ofs; // R11 R12 R18
      UPD_INC: n = a + sz;
      UPD_DEC: n = a - sz;
    endcase
    return n;
  endfunction : next_addr

  logic enabled;
  logic edge_sense;
  logic ext_src;
  logic runnable;
  logic req_low;
  logic req_fall;
  logic req_hit;
  logic [31:0] sz;
  logic wb_hit;
  logic wb_wr;
  logic sw_en_rise;
  logic [31:0] mode_view;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_gate;

  always_comb begin
    enabled = r.mode[XFER_EN_BIT];
    edge_sense = r.mode[REQ_SENSE_BIT];
    ext_src = (r.mode[SRC_SEL_LSB +: 2] == SRC_EXT); // R6
    // Only dual address, normal mode is built; other codes hold the channel idle
    runnable = enabled && (r.mode[MODE_LSB +: 2] == MODE_NORMAL) // R1 R5
               && (r.addrctl[AMODE_BIT] == AMODE_DUAL) // R10
               && (r.count != RST_WORD);
    req_low = !ext_transfer_request_n_in;
    req_fall = r.req_prev && !ext_transfer_request_n_in;
    // Non-pin sources run as auto request: no peripheral interrupt can start us
    if (!ext_src) begin // R16
      req_hit = 1'b1;
    end else if (edge_sense) begin // R2
      req_hit = req_fall || r.edge_pend || (r.first_pend && req_low); // R3
    end else begin
      req_hit = req_low;
    end
    sz = size_bytes(r.mode[SIZE_LSB +: 2]);
    mode_view = r.mode;
    mode_view[END_FLAG_BIT] = r.sts[IRQ_END_BIT]; // R9
    wb_hit = 1'b1;
    unique case (wb_adr_in)
      REG_SRC: rd_mux = r.src;
      REG_DST: rd_mux = r.dst;
      REG_STEP: rd_mux = r.step;
      REG_COUNT: rd_mux = r.count;
      REG_MODE: rd_mux = mode_view;
      REG_ADDRCTL: rd_mux = r.addrctl;
      REG_IRQ_STS: rd_mux = {{(32-IRQ_W){1'b0}}, r.sts};
      REG_IRQ_MSK: rd_mux = {{(32-IRQ_W){1'b0}}, r.msk};
      default: begin
        rd_mux = RST_WORD;
        wb_hit = 1'b0;
      end
    endcase
    wb_wr = wb_cyc_in && wb_stb_in && wb_we_in && !r.wb_ack && wb_hit;
    // End interrupt is only passed when its enable bit is set
    irq_gate = r.msk;
    irq_gate[IRQ_END_BIT] = r.msk[IRQ_END_BIT] && r.mode[END_IE_BIT]; // R8
  end

  always_comb begin
    nxt = r;
    irq_set = RST_IRQ;
    sw_en_rise = 1'b0;
    nxt.req_prev = ext_transfer_request_n_in;

    // Wishbone slave: ack one cycle after the request, dropped the next cycle
    nxt.wb_ack = wb_cyc_in && wb_stb_in && !r.wb_ack;
    nxt.wb_dat = (wb_cyc_in && wb_stb_in && !r.wb_ack && !wb_we_in) ? rd_mux : RST_WORD;

    // An edge seen without grant or mid transfer waits here, else it would be lost
    if (!enabled) begin
      nxt.edge_pend = 1'b0;
    end else if (req_fall && ext_src && edge_sense) begin // R2
      nxt.edge_pend = 1'b1;
    end

    // Transfer engine
    unique case (r.st)
      ST_IDLE: begin
        if (runnable && req_hit && bus_gnt_in) begin
          nxt.first_pend = 1'b0;
          // A new edge in the start cycle stays pending for the next transfer
          nxt.edge_pend = r.edge_pend && req_fall; // R2
          nxt.st = ST_READ;
          nxt.mem_req = 1'b1;
          nxt.mem_we = 1'b0;
          nxt.mem_addr = r.src;
        end
      end
      ST_READ: begin
        if (mem_ack_in) begin
          nxt.hold = mem_rdata_in;
          nxt.st = ST_WRITE;
          nxt.mem_we = 1'b1;
          nxt.mem_addr = r.dst;
          nxt.mem_wdata = mem_rdata_in;
        end
      end
      ST_WRITE: begin
        if (mem_ack_in) begin
          nxt.st = ST_STEP;
          nxt.mem_req = 1'b0;
          nxt.mem_we = 1'b0;
        end
      end
      ST_STEP: begin
        nxt.st = ST_IDLE;
        nxt.src = next_addr(r.src, r.addrctl[SUPD_LSB +: 2], sz, r.step); // R13
        nxt.dst = next_addr(r.dst, r.addrctl[DUPD_LSB +: 2], sz, r.step); // R14
        irq_set[IRQ_BEAT_BIT] = 1'b1;
        if (r.count <= sz) begin
          nxt.count = RST_WORD; // R15
          nxt.mode[XFER_EN_BIT] = 1'b0; // R17
          irq_set[IRQ_END_BIT] = 1'b1; // R17
        end else begin
          nxt.count = r.count - sz; // R15
        end
      end
    endcase

    // Software writes win over the hardware update of the same register, except interrupt status
    if (wb_wr) begin
      unique case (wb_adr_in)
        REG_SRC: nxt.src = apply_sel(r.src, wb_dat_in, wb_sel_in);
        REG_DST: nxt.dst = apply_sel(r.dst, wb_dat_in, wb_sel_in);
        REG_STEP: nxt.step = apply_sel(r.step, wb_dat_in, wb_sel_in);
        REG_COUNT: nxt.count = apply_sel(r.count, wb_dat_in, wb_sel_in);
        REG_MODE: begin
          nxt.mode = apply_sel(r.mode, wb_dat_in, wb_sel_in) & MODE_WMASK;
          sw_en_rise = !r.mode[XFER_EN_BIT] && nxt.mode[XFER_EN_BIT];
        end
        REG_ADDRCTL: nxt.addrctl = apply_sel(r.addrctl, wb_dat_in, wb_sel_in) & ADDRCTL_WMASK;
        REG_IRQ_STS: begin
          if (wb_sel_in[0]) begin
            nxt.sts = r.sts & ~wb_dat_in[IRQ_W-1:0];
          end
        end
        REG_IRQ_MSK: begin
          if (wb_sel_in[0]) begin
            nxt.msk = wb_dat_in[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // A fresh enable arms the level-sensed first request
    if (sw_en_rise) begin
      nxt.first_pend = 1'b1; // R3
    end

    // Hardware set beats a write-one-to-clear in the same cycle
    nxt.sts = nxt.sts | irq_set; // R9
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r.st <= ST_IDLE;
      r.src <= RST_WORD;
      r.dst <= RST_WORD;
      r.step <= RST_WORD;
      r.count <= RST_WORD;
      r.mode <= RST_WORD;
      r.addrctl <= RST_WORD;
      r.sts <= RST_IRQ;
      r.msk <= RST_IRQ;
      r.first_pend <= 1'b0;
      r.req_prev <= 1'b1;
      r.edge_pend <= 1'b0;
      r.hold <= RST_WORD;
      r.wb_ack <= 1'b0;
      r.wb_dat <= RST_WORD;
      r.mem_req <= 1'b0;
      r.mem_we <= 1'b0;
      r.mem_addr <= RST_WORD;
      r.mem_wdata <= RST_WORD;
    end else begin
      r <= nxt;
    end
  end

  // Bus is requested while the channel could use it or holds it
  assign bus_req_out = (r.st != ST_IDLE) || (runnable && req_hit);
  assign cpu_priority_out = r.mode[PRIO_LSB +: 3]; // R7
  assign wb_ack_out = r.wb_ack;
  assign wb_dat_out = r.wb_dat;
  assign mem_req_out = r.mem_req;
  assign mem_we_out = r.mem_we;
  assign mem_addr_out = r.mem_addr;
  assign mem_size_out = r.mode[SIZE_LSB +: 2]; // R4
  assign mem_wdata_out = r.mem_wdata;
  assign irq_out = |(r.sts & irq_gate); // R8

endmodule : edc_channel

// *** sim/edc_channel_props.sv ***
// Port checker for the DMA channel and its bind
`timescale 1ns/1ps
module edc_channel_props
  import edc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [23:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic bus_gnt_in,
  input wire logic [2:0] cpu_priority_out,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic [31:0] mem_rdata_in,
  input wire logic mem_ack_in,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  AST_GNT: assert property ($rose(mem_req_out) |-> $past(bus_gnt_in))
    else $error("start without grant");
  AST_READ_FIRST: assert property ($rose(mem_req_out) |-> !mem_we_out)
    else $error("transfer not opened by read");
  AST_COPY: assert property (mem_req_out && !mem_we_out && mem_ack_in |=>
    mem_req_out && mem_we_out && mem_wdata_out[7:0] == $past(mem_rdata_in[7:0]))
    else $error("write does not carry read byte");
  AST_GAP: assert property (mem_req_out && mem_we_out && mem_ack_in |=>
    !mem_req_out [*2])
    else $error("no step and idle after write");
  AST_HOLD: assert property (mem_req_out && !mem_ack_in |=>
    $stable(mem_addr_out) && $stable(mem_we_out))
    else $error("memory request changed before ack");
  AST_PRIO: assert property (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
    wb_adr_in == REG_MODE && wb_sel_in[0] |=> cpu_priority_out == $past(wb_dat_in[2:0]))
    else $error("priority output wrong");
  AST_MASK_OFF: assert property (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out &&
    wb_adr_in == REG_IRQ_MSK && wb_sel_in[0] && wb_dat_in[1:0] == 2'h0 |=> ##1 !irq_out)
    else $error("masked interrupt still high");
endmodule : edc_channel_props
bind edc_channel edc_channel_props i_edc_channel_props (.clk_in, .srst_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .bus_gnt_in,
  .cpu_priority_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
  .mem_rdata_in, .mem_ack_in, .irq_out);

// *** sim/edc_mem_model.sv ***
// External memory model with programmable wait
`timescale 1ns/1ps
module edc_mem_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [3:0] wait_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [31:0] mem_wdata_in,
  output logic [31:0] mem_rdata_out,
  output logic mem_ack_out
);
  logic [3:0] cnt_r;
  logic [31:0] wr_data;
  always_ff @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    // Data is only valid with ack, so it toggles otherwise
    mem_rdata_out <= ~mem_rdata_out;
    if (srst_in) begin
      cnt_r <= 4'h0;
      mem_rdata_out <= 32'h0;
      wr_data <= 32'h0;
    end else if (!mem_req_in || mem_ack_out) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == wait_in) begin
      mem_ack_out <= 1'b1;
      cnt_r <= 4'h0;
      if (mem_we_in) begin
        wr_data <= mem_wdata_in;
      end else begin
        mem_rdata_out <= {24'h0, mem_addr_in[7:0] ^ 8'hA5};
      end
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : edc_mem_model

// *** sim/edc_channel_bench.sv ***
// Self-checking bench for the DMA channel
`timescale 1ns/1ps
module edc_channel_bench;
  import edc_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req_n = 1'b1, gnt = 1'b1, ack, irq, mreq, mwe, mack;
  logic breq;
  logic [23:0] adr = 24'h0;
  logic [31:0] dat = 32'h0, rdat, maddr, mwd, mrd, q;
  logic [3:0] sel = 4'hF, wt = 4'h0;
  logic [2:0] prio;
  logic [1:0] msz;
  int error_cnt = 0, checked = 0;
  always #50 clk_in = ~clk_in;
  edc_channel i_edc_channel (.clk_in, .srst_in, .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .ext_transfer_request_n_in(req_n), .bus_req_out(breq), .bus_gnt_in(gnt),
    .cpu_priority_out(prio), .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr),
    .mem_size_out(msz), .mem_wdata_out(mwd), .mem_rdata_in(mrd), .mem_ack_in(mack),
    .irq_out(irq));
  edc_mem_model i_edc_mem_model (.clk_in, .srst_in, .wait_in(wt), .mem_req_in(mreq),
    .mem_we_in(mwe), .mem_addr_in(maddr), .mem_wdata_in(mwd), .mem_rdata_out(mrd),
    .mem_ack_out(mack));
  task automatic wb(input logic w, input logic [23:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rd(input string s, input logic [23:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask : rd
  // Ends two edges after the write ack, when the step has landed
  task automatic xfer_done();
    do @(posedge clk_in); while (!(mwe === 1'b1 && mack === 1'b1));
    repeat (2) @(posedge clk_in);
  endtask : xfer_done
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic t_regs();
    rd("src", REG_SRC, RST_WORD);
    rd("mode", REG_MODE, RST_WORD);
    wb(1'b1, REG_MODE, 32'h7FFF_FFFF);
    rd("mode", REG_MODE, MODE_WMASK & 32'h7FFF_FFFF);
    chk("prio", {29'h0, prio}, 32'h7);
    wb(1'b1, 24'hFFFCA4, 32'hFFFF_FFFF);
    rd("hole", 24'hFFFCA4, 32'h0);
    wb(1'b1, REG_MODE, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_edge();
    wb(1'b1, REG_SRC, 32'h100);
    wb(1'b1, REG_DST, 32'h200);
    wb(1'b1, REG_STEP, 32'h2);
    wb(1'b1, REG_COUNT, 32'h2);
    wb(1'b1, REG_ADDRCTL, 32'h0011_0000);
    wb(1'b1, REG_IRQ_MSK, 32'h1);
    req_n <= 1'b0;
    wb(1'b1, REG_MODE, 32'h8800_01C7);
    xfer_done();
    chk("waddr", maddr, 32'h200);
    chk("size", {30'h0, msz}, {30'h0, SIZE_BYTE});
    rd("src", REG_SRC, 32'h102);
    rd("dst", REG_DST, 32'h202);
    rd("cnt", REG_COUNT, 32'h1);
    chk("wdata", i_edc_mem_model.wr_data, 32'hA5);
    repeat (20) @(posedge clk_in);
    rd("cnt", REG_COUNT, 32'h1);
    wt <= 4'h3;
    req_n <= 1'b1;
    gnt <= 1'b0;
    @(posedge clk_in);
    req_n <= 1'b0;
    repeat (3) @(posedge clk_in);
    // The edge came while the bus was withheld: it must still be served
    gnt <= 1'b1;
    xfer_done();
    rd("cnt", REG_COUNT, 32'h0);
    rd("src", REG_SRC, 32'h104);
    rd("dst", REG_DST, 32'h204);
    rd("mode", REG_MODE, 32'h0801_01C7);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, REG_IRQ_MSK, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'b1, REG_IRQ_MSK, 32'h1);
    wb(1'b1, REG_MODE, 32'h0800_00C7);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'b1, REG_IRQ_STS, 32'h3);
    rd("mode", REG_MODE, 32'h0800_00C7);
    $display("edge done");
  endtask : t_edge
  task automatic t_lvl();
    wb(1'b1, REG_COUNT, 32'h1);
    wb(1'b1, REG_ADDRCTL, 32'h0);
    wb(1'b1, REG_MODE, 32'h0000_00C7);
    repeat (20) @(posedge clk_in);
    rd("cnt", REG_COUNT, 32'h1);
    gnt <= 1'b0;
    wb(1'b1, REG_MODE, 32'h8000_00C7);
    repeat (20) @(posedge clk_in);
    rd("cnt", REG_COUNT, 32'h1);
    chk("busreq", {31'h0, breq}, 32'h1);
    gnt <= 1'b1;
    xfer_done();
    rd("cnt", REG_COUNT, 32'h0);
    rd("src", REG_SRC, 32'h104);
    $display("level done");
  endtask : t_lvl
  // Single address and non-normal modes must hold; then word size, auto start, inc and dec
  task automatic t_modes();
    wb(1'b1, REG_COUNT, 32'h4);
    wb(1'b1, REG_ADDRCTL, 32'h8000_0000);
    wb(1'b1, REG_MODE, 32'h8000_4000);
    repeat (20) @(posedge clk_in);
    rd("cnt", REG_COUNT, 32'h4);
    chk("busreq", {31'h0, breq}, 32'h0);
    wb(1'b1, REG_MODE, 32'h8000_5000);
    wb(1'b1, REG_ADDRCTL, 32'h0023_0000);
    repeat (20) @(posedge clk_in);
    rd("cnt", REG_COUNT, 32'h4);
    wb(1'b1, REG_MODE, 32'h8000_4000);
    xfer_done();
    xfer_done();
    chk("waddr", maddr, 32'h202);
    chk("wdata", i_edc_mem_model.wr_data, 32'hA3);
    chk("size", {30'h0, msz}, {30'h0, SIZE_WORD});
    rd("cnt", REG_COUNT, 32'h0);
    rd("src", REG_SRC, 32'h108);
    rd("dst", REG_DST, 32'h200);
    rd("mode", REG_MODE, 32'h0001_4000);
    wb(1'b1, REG_IRQ_MSK, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    $display("modes done");
  endtask : t_modes
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_edge();
    t_lvl();
    t_modes();
    wrap_up();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #(100 * 5000);
    error_cnt++;
    wrap_up();
  end
endmodule : edc_channel_bench
